// *** common/eeb_line_if.sv ***
// Conditioned two-wire bus levels and events, line stage to engine.
// Assumes all members are produced on REF_CLK.
`timescale 1ns/1ps
interface eeb_line_if;
    logic scl;      // Synchronised clock line
    logic sda;      // Synchronised data line
    logic wp;       // Synchronised write-protect level
    logic scl_rise; // One-cycle clock rising event
    logic scl_fall; // One-cycle clock falling event
    logic start;    // One-cycle start event
    logic stop;     // One-cycle stop event
    modport cond (output scl, sda, wp, scl_rise, scl_fall, start, stop);
    modport eng  (input  scl, sda, wp, scl_rise, scl_fall, start, stop);
endinterface

// *** common/eeb_pkg.sv ***
// Shared constants, field layout and state type of the EEPROM bus client.
// Assumes a 20 MHz REF_CLK and an APB master with 32-bit data.
// Bus rules this block follows or, for the host side, relies on
// RULE1: Data falling while clock stays high is taken as a start.
// RULE2: Data rising while clock stays high is taken as a stop.
// RULE3: Transmitter changes data only while clock is low, one pulse per bit.
// RULE4: Host starts a transfer only while both lines are high.
// RULE5: Host opens each command with start and closes it with stop.
// RULE6: Addressed receiver acknowledges each byte on a ninth host clock pulse.
// RULE7: Acknowledger holds data low through the whole acknowledge clock high.
// RULE8: No acknowledge at all while an internal write cycle runs.
// RULE9: Host ends a read by not acknowledging; client leaves data released.
// RULE10: First byte after start is device code, three ignored bits, R/W.
// RULE11: R/W bit one selects read, zero selects write.
// RULE12: Matching device code is acknowledged; other codes get no response.
// RULE13: Byte after write control byte loads all eight pointer bits.
// RULE14: Byte write is control, address, one data byte; stop starts writing.
// RULE15: Page write buffers up to eight bytes, committed only at stop.
// RULE16: Each data byte bumps only three low pointer bits; upper five stay.
// RULE17: Over eight bytes wraps inside the page, keeping only the last eight.
// RULE18: Host software avoids page writes that would cross a page boundary.
// RULE19: Write-protect input high inhibits every array write; low allows them.
// RULE20: Polling control byte is ignored while busy, acknowledged when done.
// RULE21: Pointer holds last accessed address plus one for current reads.
// RULE22: Read control byte is acknowledged, then one data byte shifted out.
// RULE23: Data line released when idle; any start or stop returns to idle. Here a start goes to ST_CTRL, not ST_IDLE.
package eeb_pkg;

    // Clock and write cycle timing
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned WRITE_TIME_MS    = 5;
    localparam int unsigned WRITE_CYCLES_DEF =
        WRITE_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned WCNT_W           = 24;

    // Array and page geometry
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned MEM_DEPTH = 256;
    localparam int unsigned PAGE_SIZE = 8;
    localparam int unsigned PAGE_W    = 3;
    localparam logic [7:0]  MEM_RST   = 8'hFF;

    // Serial byte framing
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam int unsigned RW_BIT   = 0;
    localparam int unsigned CODE_LSB = 4;

    // Pin synchroniser lanes and their idle levels
    localparam int unsigned PIN_SCL  = 0;
    localparam int unsigned PIN_SDA  = 1;
    localparam int unsigned PIN_WP   = 2;
    localparam logic [2:0]  SYNC_RST = 3'h3;

    // APB register map and fields
    localparam int unsigned APB_AW        = 8;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STAT      = 8'h04;
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_WP_BIT   = 1;
    localparam int unsigned STAT_ST_LSB   = 4;
    localparam int unsigned STAT_PTR_LSB  = 8;

    // Protocol engine states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CTRL,
        ST_CTRL_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_TX,
        ST_HOST_ACK,
        ST_WAIT
    } eeb_state_t;

endpackage

// *** core/eeb_line_cond.sv ***
// Pin synchroniser and bus condition detector for the EEPROM client.
// Assumes raw pins are asynchronous to clk and the bus clock is slow.
`timescale 1ns/1ps
module eeb_line_cond
    import eeb_pkg::*;
(
    input  wire logic clk,     // Block clock
    input  wire logic rst,     // Synchronous reset, active high
    input  wire logic scl_pin, // Raw bus clock
    input  wire logic sda_pin, // Raw bus data
    input  wire logic wp_pin,  // Raw write-protect
    eeb_line_if.cond  line     // Conditioned levels and events
);
    logic [2:0] meta;
    logic [2:0] sync;
    logic [1:0] prev;

    // Two flops per pin; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= SYNC_RST;
            sync <= SYNC_RST;
            prev <= SYNC_RST[1:0];
        end else begin
            meta <= {wp_pin, sda_pin, scl_pin};
            sync <= meta;
            prev <= sync[1:0];
        end
    end

    // Levels and edges seen only on the settled stage
    assign line.scl      = sync[PIN_SCL];
    assign line.sda      = sync[PIN_SDA];
    assign line.wp       = sync[PIN_WP];
    assign line.scl_rise = sync[PIN_SCL] & ~prev[PIN_SCL];
    assign line.scl_fall = ~sync[PIN_SCL] & prev[PIN_SCL];
    // Clock high on both samples, so data edges mark conditions
    assign line.start = sync[PIN_SCL] & prev[PIN_SCL] &
                        prev[PIN_SDA] & ~sync[PIN_SDA]; // RULE1
    assign line.stop  = sync[PIN_SCL] & prev[PIN_SCL] &
                        ~prev[PIN_SDA] & sync[PIN_SDA]; // RULE2
endmodule

// *** core/eeb_top.sv ***
// Two-wire EEPROM client engine with page buffer, array and APB registers.
// Assumes the bus host clocks far below REF_CLK and the pull-up is outside.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module eeb_top
    import eeb_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = eeb_pkg::WRITE_CYCLES_DEF,
    parameter logic [3:0]  DEV_CODE     = 4'h6 // Value is arbitrary
)
(
    input  wire logic                       REF_CLK, // 20 MHz clock
    input  wire logic                       SYS_RST, // Sync reset
    input  wire logic                       SCL_IN,  // Bus clock pin
    input  wire logic                       SDA_IN,  // Bus data pin
    output logic                            SDA_OUT, // Data drive level
    output logic                            SDA_OE,  // Data pull-down on
    input  wire logic                       WP_IN,   // Write-protect pin
    input  wire logic                       PSEL,    // APB select
    input  wire logic                       PENABLE, // APB enable
    input  wire logic                       PWRITE,  // APB direction
    input  wire logic [eeb_pkg::APB_AW-1:0] PADDR,   // APB byte address
    input  wire logic [31:0]                PWDATA,  // APB write data
    output logic      [31:0]                PRDATA,  // APB read data
    output logic                            PREADY,  // APB ready
    output logic                            PSLVERR  // APB error
);
    import eeb_pkg::*;

    eeb_line_if line ();

    eeb_state_t            state;
    logic [3:0]            bit_cnt;
    logic [7:0]            rx_byte;
    logic [7:0]            tx_byte;
    logic                  host_ack;
    logic                  sda_oe;
    logic                  sda_out;
    logic [ADDR_W-1:0]     ptr;
    logic [7:0]            page_buf [PAGE_SIZE];
    logic [PAGE_SIZE-1:0]  page_vld;
    logic [7:0]            mem [MEM_DEPTH];
    logic                  busy;
    logic [WCNT_W-1:0]     wcnt;
    logic                  ctrl_en;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [31:0]           stat_word;
    logic                  rx_state;
    logic                  ack_state;
    logic                  byte_end;
    logic                  code_ok;
    logic                  rw_rd;
    logic                  load_tx;
    logic                  commit;
    logic                  apb_setup;
    logic                  apb_wr;

    eeb_line_cond u_cond (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .scl_pin (SCL_IN),
        .sda_pin (SDA_IN),
        .wp_pin  (WP_IN),
        .line    (line)
    );

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    // Decisions shared by the protocol processes
    assign rx_state  = (state == ST_CTRL) || (state == ST_ADDR) ||
                       (state == ST_DATA);
    assign ack_state = (state == ST_CTRL_ACK) || (state == ST_ADDR_ACK) ||
                       (state == ST_DATA_ACK) || (state == ST_HOST_ACK);
    assign byte_end  = line.scl_fall && (bit_cnt == BIT_LAST);
    // Busy or disabled client stays silent, which is what polling sees
    assign code_ok   = (rx_byte[7:CODE_LSB] == DEV_CODE) && ctrl_en &&
                       !busy; // RULE10 RULE12 RULE8 RULE20
    assign rw_rd     = rx_byte[RW_BIT]; // RULE11
    assign load_tx   = line.scl_fall &&
                       (((state == ST_CTRL_ACK) && rw_rd) ||
                        ((state == ST_HOST_ACK) && host_ack));
    // A protected array never sees the page, and no cycle is started
    assign commit    = line.stop && !line.wp && (|page_vld) &&
                       ((state == ST_DATA) || (state == ST_DATA_ACK));

    // Protocol sequencing; conditions on the bus win over bit events
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
        end else if (line.start) begin
            state <= ST_CTRL; // RULE23
        end else if (line.stop) begin
            state <= ST_IDLE; // RULE23
        end else begin
            case (state)
                ST_CTRL: begin
                    if (byte_end) begin
                        state <= code_ok ? ST_CTRL_ACK : ST_WAIT; // RULE12
                    end
                end
                ST_CTRL_ACK: begin
                    if (line.scl_fall) begin
                        state <= rw_rd ? ST_TX : ST_ADDR; // RULE11
                    end
                end
                ST_ADDR: begin
                    if (byte_end) begin
                        state <= ST_ADDR_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    if (line.scl_fall) begin
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (byte_end) begin
                        state <= ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    if (line.scl_fall) begin
                        state <= ST_DATA;
                    end
                end
                ST_TX: begin
                    if (byte_end) begin
                        state <= ST_HOST_ACK;
                    end
                end
                ST_HOST_ACK: begin
                    if (line.scl_fall) begin
                        state <= host_ack ? ST_TX : ST_WAIT; // RULE9
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Bit counter, one count per clock pulse of a byte
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || line.start) begin
            bit_cnt <= 4'h0;
        end else if (line.scl_fall && ack_state) begin
            bit_cnt <= 4'h0;
        end else if (line.scl_rise && (rx_state || state == ST_TX)) begin
            bit_cnt <= bit_cnt + 4'h1; // RULE3
        end
    end

    // Receive shifter samples data at the clock rising edge
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            rx_byte <= 8'h00;
        end else if (line.scl_rise && rx_state) begin
            rx_byte <= {rx_byte[6:0], line.sda}; // RULE3
        end
    end

    // Host answer to a read byte, caught while its clock is high
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            host_ack <= 1'b0;
        end else if (line.scl_rise && state == ST_HOST_ACK) begin
            host_ack <= ~line.sda; // RULE9
        end
    end

    // Data pull-down; every change lands after a clock falling edge
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || line.start || line.stop) begin
            sda_oe  <= 1'b0; // RULE23
            tx_byte <= 8'h00;
        end else begin
            case (state)
                ST_CTRL: begin
                    if (byte_end) begin
                        sda_oe <= code_ok; // RULE6 RULE8 RULE12
                    end
                end
                ST_ADDR, ST_DATA: begin
                    if (byte_end) begin
                        sda_oe <= 1'b1; // RULE6 RULE14
                    end
                end
                ST_TX: begin
                    if (byte_end) begin
                        sda_oe <= 1'b0; // RULE22
                    end else if (line.scl_fall) begin
                        tx_byte <= {tx_byte[6:0], 1'b0};
                        sda_oe  <= ~tx_byte[6]; // RULE3
                    end
                end
                default: begin
                    // Ack held until the ninth pulse has fallen
                    if (load_tx) begin
                        tx_byte <= mem[ptr]; // RULE22
                        sda_oe  <= ~mem[ptr][7];
                    end else if (line.scl_fall || !ack_state) begin
                        sda_oe <= 1'b0; // RULE7 RULE9 RULE23
                    end
                end
            endcase
        end
    end

    // Open-drain: only the enable moves, the level stays low
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Address pointer; page bytes move only the low three bits
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ptr <= '0;
        end else if (state == ST_ADDR && byte_end) begin
            ptr <= rx_byte; // RULE13
        end else if (state == ST_DATA && byte_end) begin
            ptr[PAGE_W-1:0] <= ptr[PAGE_W-1:0] + 3'h1; // RULE16 RULE17
        end else if (load_tx) begin
            ptr <= ptr + 8'h01; // RULE21
        end
    end

    // Page slot flags; a new command forgets any unfinished page
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || line.start || line.stop) begin
            page_vld <= '0;
        end else if (state == ST_DATA && byte_end) begin
            page_vld[ptr[PAGE_W-1:0]] <= 1'b1; // RULE15
        end
    end

    // Page data; late bytes overwrite the oldest slot in turn
    always_ff @(posedge REF_CLK) begin
        if (state == ST_DATA && byte_end) begin
            page_buf[ptr[PAGE_W-1:0]] <= rx_byte; // RULE15 RULE17
        end
    end

    // Array; every buffered page byte lands at once on the closing stop
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= MEM_RST;
            end
        end else if (commit) begin
            for (int i = 0; i < PAGE_SIZE; i++) begin
                if (page_vld[i]) begin
                    mem[{ptr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <=
                        page_buf[i]; // RULE14 RULE15 RULE19
                end
            end
        end
    end

    // Internal write cycle timer; count shortened by the parameter
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            busy <= 1'b0;
            wcnt <= '0;
        end else if (commit) begin
            busy <= 1'b1; // RULE14 RULE20
            wcnt <= '0;
        end else if (busy) begin
            if (wcnt == WCNT_W'(WRITE_CYCLES - 1)) begin
                busy <= 1'b0;
            end else begin
                wcnt <= wcnt + 1'b1;
            end
        end
    end

    // Status word shows busy, protection, state and pointer
    always_comb begin
        stat_word = '0;
        stat_word[STAT_BUSY_BIT] = busy;
        stat_word[STAT_WP_BIT] = line.wp;
        stat_word[STAT_ST_LSB +: 4] = state;
        stat_word[STAT_PTR_LSB +: ADDR_W] = ptr;
    end

    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr    = PSEL && PENABLE && pready && PWRITE;

    // APB answer prepared in setup, so access always takes one cycle
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apb_setup) begin
                if (PADDR == REG_CTRL) begin
                    prdata[CTRL_EN_BIT] <= ctrl_en;
                end else if (PADDR == REG_STAT) begin
                    prdata <= stat_word;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Client enable; a disabled client answers no control byte
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_en <= CTRL_EN_RST;
        end else if (apb_wr && PADDR == REG_CTRL) begin
            ctrl_en <= PWDATA[CTRL_EN_BIT];
        end
    end

    assign SDA_OUT = sda_out;
    assign SDA_OE  = sda_oe;
    assign PRDATA  = prdata;
    assign PREADY  = pready;
    assign PSLVERR = pslverr;

    // Checks on the engine; bus conditions reset it from any state
    AST_START_GOES_CTRL: assert property ( // RULE1
        line.start |=> (state == ST_CTRL) && !sda_oe && bit_cnt == 4'h0)
        else $error("start did not open a control byte");

    AST_STOP_GOES_IDLE: assert property ( // RULE2
        line.stop |=> (state == ST_IDLE) && !sda_oe)
        else $error("stop did not return to idle");

    AST_DRIVE_ON_LOW: assert property ( // RULE3
        ($changed(sda_oe) && !$past(line.start) && !$past(line.stop))
        |-> !$past(line.scl))
        else $error("data drive changed while clock high");

    AST_ACK_SPANS_PULSE: assert property ( // RULE7
        (ack_state && sda_oe && line.scl && !line.start && !line.stop)
        |=> sda_oe)
        else $error("acknowledge released while clock high");

    AST_SILENT_BUSY: assert property ( // RULE8
        busy |-> !sda_oe)
        else $error("data driven during write cycle");

    AST_HOST_NACK: assert property ( // RULE9
        (state == ST_HOST_ACK && line.scl_fall && !host_ack)
        |=> !sda_oe && state == ST_WAIT)
        else $error("data held after host withheld ack");

    AST_CODE_MATCH: assert property ( // RULE12
        (state == ST_CTRL_ACK && $past(state) == ST_CTRL) |->
        $past(rx_byte[7:CODE_LSB]) == DEV_CODE && sda_oe)
        else $error("control byte acked with wrong code");

    AST_ADDR_LOAD: assert property ( // RULE13
        (state == ST_ADDR_ACK && $past(state) == ST_ADDR) |->
        ptr == $past(rx_byte))
        else $error("word address not loaded into pointer");

    AST_PAGE_COUNT: assert property ( // RULE16
        (state == ST_DATA_ACK && $past(state) == ST_DATA) |->
        ptr[7:3] == $past(ptr[7:3]) &&
        ptr[2:0] == $past(ptr[2:0]) + 3'h1)
        else $error("page byte moved pointer wrongly");

    AST_PROTECT: assert property ( // RULE19
        $rose(busy) |-> !$past(line.wp) && $past(line.stop))
        else $error("write cycle started under protection");

    AST_READ_BUMP: assert property ( // RULE21
        load_tx |=> ptr == $past(ptr) + 8'h01 && state == ST_TX)
        else $error("read did not advance pointer");

    AST_APB_ONE_WAIT: assert property (
        apb_setup |=> PREADY ##1 !PREADY)
        else $error("APB answer not one cycle after setup");
endmodule

// *** tb/eeb_host.sv ***
// Behavioural two-wire bus host that drives the serial clock.
// Assumes the resolved data wire comes back and a pull-up idles it high.
`timescale 1ns/1ps
module eeb_host (
    input  wire logic clk,   // Bench clock, 8 cycles per bit
    input  wire logic sda,   // Resolved data wire
    output logic      scl,   // Serial clock, still outside frames
    output logic      sda_oe // High pulls data low
);
    // Bus idle with both lines high
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data moves late in the low phase so no false start or stop is seen
    task automatic bit_x(input logic hb, output logic rb);
        tick(4);
        sda_oe <= !hb;
        tick(2);
        scl <= 1'b1;
        tick(1);
        rb = sda;
        tick(1);
        scl <= 1'b0;
    endtask
    // Also serves as a repeated start
    task automatic start_c();
        tick(4);
        sda_oe <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_oe <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        tick(4);
        sda_oe <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_oe <= 1'b0;
        tick(8);
    endtask
    // MSB first, then a ninth pulse for the client's answer
    task automatic put_byte(input logic [7:0] b, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], r);
        bit_x(1'b1, nak);
    endtask
    // Host answers low, or stays released after the last byte
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, b[i]);
        bit_x(last, r);
    endtask
endmodule

// *** tb/tb_eeb_top.sv ***
// Self-checking bench: APB registers and two-wire traffic to the client.
// Assumes eeb_host as the bus host and a pull-up on the data wire.
`timescale 1ns/1ps
module tb_eeb_top;
    import eeb_pkg::*;
    localparam logic [3:0] CODE = 4'h6; // Value is arbitrary
    logic REF_CLK, SCL_IN, SDA_OUT, SDA_OE, PREADY, PSLVERR, h_oe;
    logic SYS_RST = 1'b1;
    logic WP_IN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic [31:0] exp_q[$], res_q[$];
    logic [7:0] mem[256];
    int errors = 0;
    int cmp_count = 0;
    // Client pulls low only with enable set and level low
    wire sda_w = !((SDA_OE && !SDA_OUT) || h_oe);
    eeb_top #(.WRITE_CYCLES(200), .DEV_CODE(CODE)) uut (
        .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN),
        .SDA_IN(sda_w), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WP_IN(WP_IN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR));
    eeb_host u_host (.clk(REF_CLK), .sda(sda_w), .scl(SCL_IN),
        .sda_oe(h_oe));
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // Results settle by the falling edge, then meet the oldest note
    always @(negedge REF_CLK)
        while (res_q.size() > 0)
            cmp(res_q.pop_front());
    task automatic cmp(input logic [31:0] r);
        logic [31:0] e;
        e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hX;
        cmp_count++;
        if (r !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, r, e);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic limit();
        errors++;
        $display("[ERR] %0t wait limit", $time);
        print_verdict();
    endtask
    function automatic logic [7:0] cb(input logic rw);
        cb = {CODE, 3'($urandom), rw}; // Ignored bits random
    endfunction
    task automatic send(input logic [7:0] b, input logic nak);
        logic a;
        exp_q.push_back({31'h0, nak});
        u_host.put_byte(b, a);
        res_q.push_back({31'h0, a});
    endtask
    task automatic recv(input logic [7:0] e, input logic last);
        logic [7:0] b;
        exp_q.push_back({24'h0, e});
        u_host.get_byte(last, b);
        res_q.push_back({24'h0, b});
    endtask
    // Request held until PREADY is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        int n;
        n = 0;
        if (!w)
            exp_q.push_back(e);
        exp_q.push_back({31'h0, err});
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1)
            limit();
        if (!w)
            res_q.push_back(PRDATA);
        res_q.push_back({31'h0, PSLVERR});
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Idle edge so a following call never rewrites PSEL at once
        @(posedge REF_CLK);
    endtask
    initial begin
        logic [7:0] pa, ba, d;
        logic a;
        int n;
        void'($urandom(64231));
        foreach (mem[i])
            mem[i] = MEM_RST;
        repeat (16) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        apb(0, REG_CTRL, 0, 32'h1, 0);
        apb(0, REG_STAT, 0, 32'h0, 0);
        apb(0, 8'h08, 0, 32'h0, 1);
        apb(1, REG_CTRL, 0, 0, 0);
        u_host.start_c();
        send(cb(0), 1);
        apb(1, REG_CTRL, 1, 0, 0);
        u_host.start_c();
        send({~CODE, 4'h0}, 1);
        u_host.stop_c();
        $display("test registers and refusals done");
        // Ten bytes from slot 5: wrap keeps the last eight
        pa = {5'($urandom), 3'h0};
        u_host.start_c();
        send(cb(0), 0);
        send(pa + 8'h5, 0);
        for (int i = 0; i < 10; i++) begin
            d = 8'($urandom);
            mem[{pa[7:3], 3'(i + 5)}] = d;
            send(d, 0);
        end
        u_host.stop_c();
        u_host.start_c();
        send(cb(0), 1);
        n = 0;
        do begin
            u_host.start_c();
            u_host.put_byte(cb(0), a);
            n++;
        end while (a !== 1'b0 && n < 8);
        if (n == 8)
            limit();
        u_host.stop_c();
        u_host.start_c();
        send(cb(1), 0);
        recv(mem[pa + 8'h7], 1);
        u_host.stop_c();
        u_host.start_c();
        send(cb(0), 0);
        send(pa, 0);
        u_host.start_c();
        send(cb(1), 0);
        for (int i = 0; i < 8; i++)
            recv(mem[pa + 8'(i)], i == 7);
        u_host.stop_c();
        $display("test page write, polling and reads done");
        // Protected write is answered but leaves the array alone
        ba = {pa[7:3] + 5'h1, 3'h2};
        WP_IN <= 1'b1;
        u_host.start_c();
        send(cb(0), 0);
        send(ba, 0);
        send(8'h3C, 0);
        u_host.stop_c();
        apb(0, REG_STAT, 0, {16'h0, ba + 8'h1, 8'h02}, 0);
        WP_IN <= 1'b0;
        // Repeated start before any stop must drop the buffered byte
        u_host.start_c();
        send(cb(0), 0);
        send(ba, 0);
        send(8'h5A, 0);
        u_host.start_c();
        send(cb(0), 0);
        send(ba, 0);
        u_host.start_c();
        send(cb(1), 0);
        recv(8'hFF, 1);
        u_host.stop_c();
        $display("test protect and discard done");
        repeat (2) @(posedge REF_CLK);
        print_verdict();
    end
endmodule
